/* File: common/uosf_pkg.sv */
// package for the otg status flag and capability register block
// assumes an apb slave with 32-bit data and word aligned registers
package uosf_pkg;
  // register byte addresses (12-bit window)
  localparam logic [11:0] ADDR_CTRL   = 12'h0800;
  localparam logic [11:0] ADDR_STAT   = 12'h0804;
  localparam logic [11:0] ADDR_CLR    = 12'h0808;
  localparam logic [11:0] ADDR_SET    = 12'h080c;
  localparam logic [11:0] ADDR_VERS   = 12'h0818;
  localparam logic [11:0] ADDR_FEAT   = 12'h081c;
  // status flag positions
  localparam int ID_EDGE_BIT   = 0;
  localparam int VBUS_EDGE_BIT = 1;
  localparam int VBUS_REQ_BIT  = 9;
  localparam int ID_LEVEL_BIT  = 10;
  localparam int VBUS_LVL_BIT  = 11;
  // control register positions
  localparam int FREEZE_BIT    = 14;
  // writable status flags: bits 7..0 and the vbus request
  localparam logic [31:0] FLAG_MASK  = 32'h0000_02ff;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_40ff;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // feature word field positions, and the variant field of the version word
  localparam int HB_ISO_LSB    = 17;
  localparam int PHY_WIDTH_BIT = 16;
  localparam int LANE_WR_BIT   = 15;
  localparam int RAM_SIZE_LSB  = 12;
  localparam int QDEPTH_LSB    = 8;
  localparam int XLEN_BIT      = 7;
  localparam int CHAN_LSB      = 4;
  localparam int EPNUM_LSB     = 0;
  localparam int VARIANT_LSB   = 16;
endpackage

/* File: design/uosf_regs.sv */
// otg general status flags, their clear and set strobes, and the
// read-only version and capability words, all behind an apb slave.
// assumes vbus and id come straight from pads (asynchronous) and that
// pclk keeps running while the controller clock is frozen.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module uosf_regs #(
  parameter logic [11:0] VERSION       = 12'h001, // arbitrary value
  parameter logic [3:0]  VARIANT       = 4'h0,    // arbitrary value
  parameter logic [6:0]  HB_ISO_EP     = 7'h00,
  parameter logic        PHY_WIDE      = 1'b0,
  parameter logic        LANE_NATIVE   = 1'b0,
  parameter logic [2:0]  RAM_SIZE_CODE = 3'h0,
  parameter logic [3:0]  QUEUE_DEPTH   = 4'h0,
  parameter logic        XLEN_WIDE     = 1'b0,
  parameter logic [2:0]  CHAN_COUNT    = 3'h1,
  parameter logic [3:0]  EP_COUNT      = 4'h0
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pads
  input  wire logic        vbus_sense_pad,
  input  wire logic        id_sense_pin,
  // outputs
  output logic             vbus_power_request,
  output logic             clock_freeze,
  output logic             usb_irq
);

  // register map, all word aligned in a 12-bit window:
  //   control  - interrupt enables in 7..0, clock freeze in 14
  //   status   - sticky flags in 7..0, power request in 9, and the
  //              live id and vbus levels in 10 and 11
  //   clear    - write one to clear a flag, reads as zero
  //   set      - write one to set a flag, reads as zero
  //   version  - fixed version and variant
  //   features - fixed capability word
  //
  // bus timing: read data is loaded in the setup cycle and shown in
  // the access cycle, which completes at once while clk_en is high.
  // a write takes effect at the edge that closes the access cycle.
  // unmapped places answer with an error, read zero and drop writes.
  //
  // hazards: the pads know nothing of pclk, so each one passes two
  // flip-flops before the edge compare reads it; an edge and a clear
  // in the same cycle keep the flag set, so no transition is lost.
  // the freeze only locks writes here; pclk keeps running so edges
  // are still caught, which is the point of the sticky flags.
  // limitation: clk_en low stalls the bus and freezes every flag,
  // so a pad pulse shorter than the stall can go unseen.
  //
  // two-stage synchronisers and previous samples for the two pads
  logic [1:0] vbus_sync_q;  // [0] first stage, [1] second
  logic [1:0] id_sync_q;
  logic       vbus_prev_q;  // previous synchronised vbus level
  logic       id_prev_q;
  logic       edges_armed_q; // blocks a false edge just after reset
  logic [1:0] arm_pipe_q;    // counts the synchroniser fill after reset
  // register state
  logic [31:0] flags_q;     // general status flags
  logic [31:0] ctrl_q;      // enables and freeze
  logic [31:0] prdata_q;
  logic [31:0] flags_d;

  // apb decode, one cycle answer with no wait states while clk_en is high
  wire apb_acc  = psel & penable;
  wire wr_acc   = apb_acc & pwrite & clk_en;
  wire rd_acc   = apb_acc & ~pwrite;
  wire hit_ctrl = (paddr == uosf_pkg::ADDR_CTRL);
  wire hit_stat = (paddr == uosf_pkg::ADDR_STAT);
  wire hit_clr  = (paddr == uosf_pkg::ADDR_CLR);
  wire hit_set  = (paddr == uosf_pkg::ADDR_SET);
  wire hit_vers = (paddr == uosf_pkg::ADDR_VERS);
  wire hit_feat = (paddr == uosf_pkg::ADDR_FEAT);
  wire hit_any  = hit_ctrl | hit_stat | hit_clr | hit_set
                | hit_vers | hit_feat;
  wire frozen   = ctrl_q[uosf_pkg::FREEZE_BIT];

  // freeze write lock
  // while frozen only the control word accepts writes, so the
  // freeze can always be lifted again
  wire wr_ok    = wr_acc & (~frozen | hit_ctrl);
  wire [31:0] clr_vec = (wr_ok & hit_clr) ?
                        (pwdata & uosf_pkg::FLAG_MASK) : 32'h0000_0000;
  wire [31:0] set_vec = (wr_ok & hit_set) ?
                        (pwdata & uosf_pkg::FLAG_MASK) : 32'h0000_0000;

  // synchronised edge compare
  // only the second stage feeds the comparison
  wire vbus_edge = edges_armed_q & (vbus_sync_q[1] ^ vbus_prev_q);
  wire id_edge   = edges_armed_q & (id_sync_q[1] ^ id_prev_q);

  wire [31:0] vers_word =
      (32'(VARIANT) << uosf_pkg::VARIANT_LSB) | 32'(VERSION);
  // iso bits phy width lane write
  // ram size queue depth length channels
  wire [31:0] feat_word =
      (32'(HB_ISO_EP)     << uosf_pkg::HB_ISO_LSB)
    | (32'(PHY_WIDE)      << uosf_pkg::PHY_WIDTH_BIT)
    | (32'(LANE_NATIVE)   << uosf_pkg::LANE_WR_BIT)
    | (32'(RAM_SIZE_CODE) << uosf_pkg::RAM_SIZE_LSB)
    | (32'(QUEUE_DEPTH)   << uosf_pkg::QDEPTH_LSB)
    | (32'(XLEN_WIDE)     << uosf_pkg::XLEN_BIT)
    | (32'(CHAN_COUNT)    << uosf_pkg::CHAN_LSB)
    | (32'(EP_COUNT)      << uosf_pkg::EPNUM_LSB);

  // live pad levels shown beside the sticky flags
  wire [31:0] stat_word = flags_q
    | (32'(vbus_sync_q[1]) << uosf_pkg::VBUS_LVL_BIT)
    | (32'(id_sync_q[1])   << uosf_pkg::ID_LEVEL_BIT);

  wire [31:0] rd_mux =
      hit_ctrl ? ctrl_q    :
      hit_stat ? stat_word :
      hit_vers ? vers_word :
      hit_feat ? feat_word : 32'h0000_0000;

  // next flags: clear first, then set and edges win over clear
  always_comb begin
    flags_d = flags_q;
    flags_d = flags_d & ~clr_vec;
    flags_d = flags_d | set_vec;
    if (vbus_edge) begin
      flags_d[uosf_pkg::VBUS_EDGE_BIT] = 1'b1;
    end
    if (id_edge) begin
      flags_d[uosf_pkg::ID_EDGE_BIT] = 1'b1;
    end
  end

  // pad synchronisers; these run on pclk, never on the frozen clock
  // edges despite freeze
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_sync_q   <= 2'b00;
      id_sync_q     <= 2'b00;
      vbus_prev_q   <= 1'b0;
      id_prev_q     <= 1'b0;
      edges_armed_q <= 1'b0;
      arm_pipe_q    <= 2'b00;
    end else if (clk_en) begin
      vbus_sync_q   <= {vbus_sync_q[0], vbus_sense_pad};
      id_sync_q     <= {id_sync_q[0], id_sense_pin};
      vbus_prev_q   <= vbus_sync_q[1];
      id_prev_q     <= id_sync_q[1];
      // arm only once the previous sample holds a real pad level:
      // two edges fill the synchronisers, the third loads prev
      arm_pipe_q    <= {arm_pipe_q[0], 1'b1};
      edges_armed_q <= arm_pipe_q[1];
    end
  end

  // status flags; edge updates are not gated by the freeze, strobe writes are
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= uosf_pkg::STAT_RESET;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  // control word: enables in bits 7..0, freeze in bit 14
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= uosf_pkg::CTRL_RESET;
    end else if (wr_ok & hit_ctrl) begin
      ctrl_q <= pwdata & uosf_pkg::CTRL_MASK;
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en & psel & ~penable & ~pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // apb answer: setup cycle captures data, access completes at once
  // unless the clock enable is low, which stalls the access
  assign pready  = clk_en;
  assign pslverr = apb_acc & ~hit_any;
  assign prdata  = rd_acc ? prdata_q : 32'h0000_0000;

  // enable gates interrupt
  // one level irq for every unmasked flag, edges included
  assign usb_irq = |(flags_q[7:0] & ctrl_q[7:0]);
  assign vbus_power_request = flags_q[uosf_pkg::VBUS_REQ_BIT];
  assign clock_freeze       = frozen;

  // checks
  // the properties below watch only what this block drives; each is
  // clocked on pclk and switched off while reset is held, since the
  // flags and the control word are forced to zero then.
  // the phy width, ram size, queue depth and channel fields are compared with the build parameters directly,
  // not with the assembled word, so a wrong shift shows up.
  // a synchronised vbus change must set the flag one cycle later
  vbus_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en & edges_armed_q & (vbus_sync_q[1] != vbus_prev_q))
      |=> flags_q[uosf_pkg::VBUS_EDGE_BIT])
    else $error("vbus edge not flagged");
  id_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en & id_edge) |=> flags_q[uosf_pkg::ID_EDGE_BIT])
    else $error("id edge not flagged");
  freeze_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en & frozen & vbus_edge) |=> flags_q[uosf_pkg::VBUS_EDGE_BIT])
    else $error("edge lost during freeze");
  clear_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_vec[uosf_pkg::ID_EDGE_BIT] & ~id_edge & ~set_vec[0])
      |=> !flags_q[uosf_pkg::ID_EDGE_BIT])
    else $error("clear strobe ignored");
  set_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (set_vec[uosf_pkg::VBUS_REQ_BIT]) |=> vbus_power_request)
    else $error("set strobe ignored");
  strobe_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc & (hit_clr | hit_set) & pready) |-> prdata == 32'h0000_0000)
    else $error("strobe location read nonzero");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    usb_irq == |(flags_q[7:0] & ctrl_q[7:0]))
    else $error("irq mismatch");
  freeze_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (frozen & wr_acc & hit_set & ~vbus_edge & ~id_edge)
      |=> flags_q == $past(flags_q))
    else $error("write took effect while frozen");
  feat_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc & hit_feat & pready) |-> prdata == feat_word)
    else $error("feature word wrong");

  vbus_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_q[uosf_pkg::VBUS_EDGE_BIT] & ~clr_vec[uosf_pkg::VBUS_EDGE_BIT])
      |=> flags_q[uosf_pkg::VBUS_EDGE_BIT])
    else $error("vbus flag dropped");

  id_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_q[uosf_pkg::ID_EDGE_BIT] & ~clr_vec[uosf_pkg::ID_EDGE_BIT])
      |=> flags_q[uosf_pkg::ID_EDGE_BIT])
    else $error("id flag dropped");

  // no vbus flag without a cause
  vbus_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (~flags_q[uosf_pkg::VBUS_EDGE_BIT] & ~vbus_edge
      & ~set_vec[uosf_pkg::VBUS_EDGE_BIT])
      |=> !flags_q[uosf_pkg::VBUS_EDGE_BIT])
    else $error("vbus flag set without edge");

  // no id flag without a cause
  id_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (~flags_q[uosf_pkg::ID_EDGE_BIT] & ~id_edge
      & ~set_vec[uosf_pkg::ID_EDGE_BIT])
      |=> !flags_q[uosf_pkg::ID_EDGE_BIT])
    else $error("id flag set without edge");

  vbus_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_vec[uosf_pkg::VBUS_EDGE_BIT] & ~vbus_edge
      & ~set_vec[uosf_pkg::VBUS_EDGE_BIT])
      |=> !flags_q[uosf_pkg::VBUS_EDGE_BIT])
    else $error("vbus clear ignored");

  clear_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok & hit_clr & ~pwdata[uosf_pkg::ID_EDGE_BIT]
      & flags_q[uosf_pkg::ID_EDGE_BIT])
      |=> flags_q[uosf_pkg::ID_EDGE_BIT])
    else $error("clear hit a zero bit");

  id_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_vec[uosf_pkg::ID_EDGE_BIT] |=> flags_q[uosf_pkg::ID_EDGE_BIT])
    else $error("set strobe ignored on flag");

  req_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_vec[uosf_pkg::VBUS_REQ_BIT] & ~set_vec[uosf_pkg::VBUS_REQ_BIT])
      |=> !vbus_power_request)
    else $error("power request not cleared");

  vbus_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_q[uosf_pkg::VBUS_EDGE_BIT] & ctrl_q[uosf_pkg::VBUS_EDGE_BIT])
      |-> usb_irq)
    else $error("vbus irq missing");

  id_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_q[uosf_pkg::ID_EDGE_BIT] & ctrl_q[uosf_pkg::ID_EDGE_BIT])
      |-> usb_irq)
    else $error("id irq missing");

  irq_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((flags_q[7:0] & ctrl_q[7:0]) == 8'h00) |-> !usb_irq)
    else $error("irq from masked flag");

  unfreeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    (frozen & wr_acc & hit_ctrl)
      |=> ctrl_q == ($past(pwdata) & uosf_pkg::CTRL_MASK))
    else $error("freeze could not be lifted");

  vers_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc & hit_vers & pready)
      |-> prdata[11:0] == VERSION)
    else $error("version wrong");

  phy_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc & hit_feat & pready)
      |-> prdata[uosf_pkg::PHY_WIDTH_BIT] == PHY_WIDE)
    else $error("phy width bit wrong");

  ram_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc & hit_feat & pready)
      |-> prdata[uosf_pkg::RAM_SIZE_LSB +: 3] == RAM_SIZE_CODE)
    else $error("ram size code wrong");

  qdepth_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc & hit_feat & pready)
      |-> prdata[uosf_pkg::QDEPTH_LSB +: 4] == QUEUE_DEPTH)
    else $error("queue depth wrong");

  chan_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc & hit_feat & pready)
      |-> prdata[uosf_pkg::CHAN_LSB +: 3] == CHAN_COUNT)
    else $error("channel count wrong");

endmodule

/* File: test/uosf_pad_model.sv */
// pad model: drives the vbus sense pad and the id sense pin
// assumes the bench calls the flip tasks between apb transfers
`timescale 1ns/1ps
module uosf_pad_model (
  // pad levels
  output logic vbus_pad,
  output logic id_pad
);
  // both pads start low
  initial begin
    vbus_pad = 1'b0;
    id_pad   = 1'b0;
  end
  // asynchronous pad change
  // the change is placed off the edge on purpose: pads know no pclk
  task automatic flip_vbus();
    #3 vbus_pad = ~vbus_pad;
  endtask
  task automatic flip_id();
    #3 id_pad = ~id_pad;
  endtask
endmodule

/* File: test/uosf_regs_test.sv */
// bench for the otg status flag and capability register block
// assumes pclk stays running; clk_en is driven by the bench
`timescale 1ns/1ps
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin \
  mismatches++; $display("unexpected %0t: %h not %h", $time, g, w); end end
module uosf_regs_test;
  // apb drive and design outputs
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, vbus_pad, id_pad, vreq, frz, irq;
  int          mismatches  = 0;
  int          checks_done = 0;
  // short names for the map
  localparam logic [11:0] CTL = uosf_pkg::ADDR_CTRL;
  localparam logic [11:0] STA = uosf_pkg::ADDR_STAT;
  localparam logic [11:0] CLR = uosf_pkg::ADDR_CLR;
  localparam logic [11:0] SET = uosf_pkg::ADDR_SET;
  localparam logic [11:0] VER = uosf_pkg::ADDR_VERS;
  localparam logic [11:0] FEA = uosf_pkg::ADDR_FEAT;
  localparam logic [31:0] FM  = uosf_pkg::FLAG_MASK;
  localparam logic [31:0] ONE = 32'hffff_ffff;
  // expected words from the build values chosen below
  localparam logic [31:0] XV = {12'h000, 4'h5, 4'h0, 12'h123};
  localparam logic [31:0] XF = {8'h00, 7'h55, 1'b0, 1'b0, 3'h7, 4'h0,
                                1'b0, 3'h7, 4'h0};
  uosf_pad_model pads_u (.vbus_pad(vbus_pad), .id_pad(id_pad));
  uosf_regs #(.VERSION(12'h123), .VARIANT(4'h5), .HB_ISO_EP(7'h55),
    .RAM_SIZE_CODE(3'h7), .CHAN_COUNT(3'h7)) dut_u (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vbus_sense_pad(vbus_pad),
    .id_sense_pin(id_pad), .vbus_power_request(vreq),
    .clock_freeze(frz), .usb_irq(irq));
  // free running 100 MHz clock
  always #5 pclk = ~pclk;
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) mismatches++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // masked read and compare
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd & m, x)
  endtask
  // reset values, strobe reads and an unmapped place
  task automatic t_reset();
    rchk(STA, FM, 32'h0000_0000);
    rchk(CTL, ONE, 32'h0000_0000);
    `CHK({irq, vreq, frz}, 3'b000)
    apb(1'b1, CLR, 32'h0000_00ff);
    rchk(CLR, ONE, 32'h0000_0000);
    rchk(SET, ONE, 32'h0000_0000);
    apb(1'b0, 12'h900, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    $display("test reset done");
  endtask
  // capability words, before and after writes to them
  task automatic t_caps();
    for (int i = 0; i < 2; i++) begin
      rchk(VER, ONE, XV);
      rchk(FEA, ONE, XF);
      apb(1'b1, VER, ONE);
      apb(1'b1, FEA, ONE);
    end
    $display("test caps done");
  endtask
  // pad edges, clear strobe and enable gating
  task automatic t_edges();
    apb(1'b1, CTL, 32'h0000_0003);
    pads_u.flip_vbus();
    repeat (6) @(posedge pclk);
    rchk(STA, FM, 32'h0000_0002);
    `CHK(irq, 1'b1)
    apb(1'b1, CLR, 32'h0000_0001);
    rchk(STA, FM, 32'h0000_0002);
    apb(1'b1, CLR, 32'h0000_0002);
    repeat (6) @(posedge pclk);
    rchk(STA, FM, 32'h0000_0000);
    `CHK(irq, 1'b0)
    pads_u.flip_id();
    repeat (6) @(posedge pclk);
    rchk(STA, FM, 32'h0000_0001);
    `CHK(irq, 1'b1)
    apb(1'b1, CLR, 32'h0000_0001);
    apb(1'b1, CTL, 32'h0000_0001);
    pads_u.flip_vbus();
    repeat (6) @(posedge pclk);
    rchk(STA, FM, 32'h0000_0002);
    `CHK(irq, 1'b0)
    apb(1'b1, CLR, 32'h0000_0002);
    $display("test edges done");
  endtask
  // set strobe and the vbus power request
  task automatic t_set();
    apb(1'b1, SET, 32'h0000_0204);
    rchk(STA, FM, 32'h0000_0204);
    `CHK(vreq, 1'b1)
    apb(1'b1, CLR, 32'h0000_0200);
    rchk(STA, FM, 32'h0000_0004);
    `CHK(vreq, 1'b0)
    apb(1'b1, CLR, 32'h0000_0004);
    $display("test set done");
  endtask
  // freeze blocks writes but not edge detection
  task automatic t_freeze();
    apb(1'b1, CTL, 32'h0000_4001);
    @(negedge pclk);
    `CHK(frz, 1'b1)
    apb(1'b1, SET, 32'h0000_0008);
    pads_u.flip_id();
    repeat (6) @(posedge pclk);
    rchk(STA, FM, 32'h0000_0001);
    `CHK(irq, 1'b1)
    apb(1'b1, CTL, 32'h0000_0000);
    @(negedge pclk);
    `CHK({frz, irq}, 2'b00)
    $display("test freeze done");
  endtask
  // clock enable low freezes detection; the edge shows once it is high
  task automatic t_hold();
    apb(1'b1, CLR, 32'h0000_00ff);
    apb(1'b1, CTL, 32'h0000_0001);
    @(posedge pclk);
    clk_en <= 1'b0;
    pads_u.flip_id();
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    `CHK({pready, irq}, 2'b00)
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(STA, FM, 32'h0000_0001);
    `CHK(irq, 1'b1)
    $display("test hold done");
  endtask
  // reset in mid-run with both pads high: no flag may follow it
  task automatic t_rst2();
    pads_u.flip_vbus();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk(STA, FM, 32'h0000_0000);
    rchk(CTL, ONE, 32'h0000_0000);
    `CHK({irq, vreq, frz}, 3'b000)
    $display("test reset again done");
  endtask
  // verdict, reached from the end of the run or the watchdog
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence after twenty cycles of reset
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_caps();
    t_edges();
    t_set();
    t_freeze();
    t_hold();
    t_rst2();
    stop_test();
  end
  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    #50000;
    mismatches++;
    stop_test();
  end
endmodule
